// ---- pkg/rtcb_pkg.sv ----
// Purpose: Shared constants and types for the serial real-time clock block
// Assumes: 200 MHz system clock, 32.768 kHz crystal sampled as a plain input
// Notes:   Register indices are the command-byte bits 5..1
package rtcb_pkg;

    //--------------------------------------------------------------------
    // Timing and identity
    //--------------------------------------------------------------------
    localparam int         OSC_HZ       = 32768;   // Crystal cycles per second
    localparam logic [6:0] SLAVE_ID     = 7'h50;   // Arbitrary value
    localparam int         SRAM_DEPTH   = 31;

    //--------------------------------------------------------------------
    // Command byte fields
    //--------------------------------------------------------------------
    localparam int         CMD_WEN_BIT  = 7;
    localparam int         CMD_MEM_BIT  = 6;
    localparam int         CMD_RD_BIT   = 0;

    //--------------------------------------------------------------------
    // Register indices
    //--------------------------------------------------------------------
    localparam logic [4:0] IDX_SEC      = 5'h00;
    localparam logic [4:0] IDX_MIN      = 5'h01;
    localparam logic [4:0] IDX_HR       = 5'h02;
    localparam logic [4:0] IDX_DATE     = 5'h03;
    localparam logic [4:0] IDX_MON      = 5'h04;
    localparam logic [4:0] IDX_DAY      = 5'h05;
    localparam logic [4:0] IDX_YEAR     = 5'h06;
    localparam logic [4:0] IDX_CTRL     = 5'h07;
    localparam logic [4:0] IDX_CENT     = 5'h09;
    localparam logic [4:0] IDX_RSVD     = 5'h0b;
    localparam logic [4:0] IDX_BURST    = 5'h1f;

    //--------------------------------------------------------------------
    // Reset values and field positions
    //--------------------------------------------------------------------
    localparam logic [7:0] RST_SEC      = 8'h00;
    localparam logic [7:0] RST_MIN      = 8'h00;
    localparam logic [7:0] RST_HR       = 8'h00;
    localparam logic [7:0] RST_DATE     = 8'h01;
    localparam logic [7:0] RST_MON      = 8'h01;
    localparam logic [7:0] RST_DAY      = 8'h01;
    localparam logic [7:0] RST_YEAR     = 8'h70;
    localparam logic [7:0] RST_CTRL     = 8'h00;
    localparam logic [7:0] RST_CENT     = 8'h19;
    localparam logic [7:0] RST_RSVD     = 8'h07;
    localparam int         HR_MODE12_BIT = 7;
    localparam int         HR_PM_BIT    = 5;

    typedef enum logic [2:0] {ST_IDLE, ST_ID, ST_CMD, ST_WR, ST_RD} rtcb_state_t;

endpackage

// ---- logic/rtcb_cal.sv ----
// Purpose: BCD clock and calendar counters with register write port
// Assumes: tick_i is a one-cycle pulse once per second
// Notes:   A write in the tick cycle wins over the count
`timescale 1ns/10ps
module rtcb_cal import rtcb_pkg::*; (
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       tick_i,
    input  wire logic       wr_i,
    input  wire logic [4:0] wr_idx_i,
    input  wire logic [7:0] wr_data_i,
    output logic [7:0]      sec_o,
    output logic [7:0]      min_o,
    output logic [7:0]      hr_o,
    output logic [7:0]      date_o,
    output logic [7:0]      mon_o,
    output logic [7:0]      day_o,
    output logic [7:0]      year_o,
    output logic [7:0]      ctrl_o,
    output logic [7:0]      cent_o
);

    //--------------------------------------------------------------------
    // BCD helpers
    //--------------------------------------------------------------------
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction

    // Two-digit BCD divisible by four: (2*tens + ones) mod 4
    function automatic logic div4(input logic [7:0] v);
        div4 = (2'(v[1:0] + {v[4], 1'b0}) == 2'b00);
    endfunction

    // Year 00 leans on the century, so 2000 leaps and 2100 does not
    function automatic logic [7:0] mdays(input logic [7:0] m, input logic [7:0] y,
                                         input logic [7:0] c);
        logic leap;
        leap = (y == 8'h00) ? div4(c) : div4(y);
        case (m)
            8'h02:                      mdays = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: mdays = 8'h30;
            default:                    mdays = 8'h31;
        endcase
    endfunction

    //--------------------------------------------------------------------
    // Carry chain
    //--------------------------------------------------------------------
    logic hr12;
    logic c_s, c_m, c_h, c_d, c_mo, c_y;
    assign hr12 = hr_o[HR_MODE12_BIT];
    assign c_s  = tick_i && sec_o == 8'h59;
    assign c_m  = c_s && min_o == 8'h59;
    assign c_h  = c_m && (hr12 ? (hr_o[HR_PM_BIT] && hr_o[4:0] == 5'h11)
                               : hr_o == 8'h23);
    assign c_d  = c_h && date_o == mdays(mon_o, year_o, cent_o);
    assign c_mo = c_d && mon_o == 8'h12;
    assign c_y  = c_mo && year_o == 8'h99;

    // Counters; writes take precedence so software always lands its value
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sec_o  <= RST_SEC;
            min_o  <= RST_MIN;
            hr_o   <= RST_HR;
            date_o <= RST_DATE;
            mon_o  <= RST_MON;
            day_o  <= RST_DAY;
            year_o <= RST_YEAR;
            ctrl_o <= RST_CTRL;
            cent_o <= RST_CENT;
        end else if (wr_i) begin
            case (wr_idx_i)
                IDX_SEC:  sec_o  <= wr_data_i;
                IDX_MIN:  min_o  <= wr_data_i;
                IDX_HR:   hr_o   <= wr_data_i;
                IDX_DATE: date_o <= wr_data_i;
                IDX_MON:  mon_o  <= wr_data_i;
                IDX_DAY:  day_o  <= wr_data_i;
                IDX_YEAR: year_o <= wr_data_i;
                IDX_CTRL: ctrl_o <= wr_data_i;
                IDX_CENT: cent_o <= wr_data_i;
                default: ;
            endcase
        end else if (tick_i) begin
            sec_o <= c_s ? 8'h00 : bcd_inc(sec_o);
            if (c_s) begin
                min_o <= c_m ? 8'h00 : bcd_inc(min_o);
            end
            if (c_m) begin
                if (!hr12) begin
                    hr_o <= (hr_o == 8'h23) ? 8'h00 : bcd_inc(hr_o);
                end else if (hr_o[4:0] == 5'h12) begin
                    hr_o[4:0] <= 5'h01;
                end else begin
                    hr_o[4:0] <= 5'(bcd_inc({3'h0, hr_o[4:0]}));
                    if (hr_o[4:0] == 5'h11) begin
                        hr_o[HR_PM_BIT] <= ~hr_o[HR_PM_BIT];
                    end
                end
            end
            if (c_h) begin
                day_o  <= (day_o == 8'h07) ? 8'h01 : bcd_inc(day_o);
                date_o <= c_d ? 8'h01 : bcd_inc(date_o);
            end
            if (c_d) begin
                mon_o <= c_mo ? 8'h01 : bcd_inc(mon_o);
            end
            if (c_mo) begin
                year_o <= c_y ? 8'h00 : bcd_inc(year_o);
            end
            if (c_y) begin
                cent_o <= bcd_inc(cent_o);
            end
        end
    end

    //--------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------
    sec_wrap_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (tick_i && !wr_i && sec_o == 8'h59)
        |=> (sec_o == 8'h00 && min_o != $past(min_o)))
        else $error("seconds rollover did not carry into minutes");
    bcd_digit_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $rose(tick_i) && !wr_i && sec_o[3:0] == 4'h9 |=> sec_o[3:0] == 4'h0)
        else $error("seconds ones digit left BCD range");
    feb_leap_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (c_h && !wr_i && mon_o == 8'h02 && date_o == 8'h28 && year_o == 8'h04)
        |=> (date_o == 8'h29 && mon_o == 8'h02))
        else $error("leap February ended early");
    month_len_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (c_h && !wr_i && mon_o == 8'h02 && date_o == 8'h28 && year_o == 8'h03)
        |=> (date_o == 8'h01 && mon_o == 8'h03))
        else $error("short month did not roll over");
    dow_wrap_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (c_h && !wr_i && day_o == 8'h07) |=> day_o == 8'h01)
        else $error("weekday did not wrap after seven");
    pm_flip_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (c_m && !wr_i && hr12 && hr_o[4:0] == 5'h11)
        |=> (hr_o[4:0] == 5'h12 && hr_o[HR_PM_BIT] != $past(hr_o[HR_PM_BIT])))
        else $error("12-hour mode did not toggle PM at twelve");

endmodule

// ---- logic/rtcb_top.sv ----
// Purpose: Two-wire serial slave giving access to clock registers and scratchpad
// Assumes: Serial clock, data and crystal are asynchronous pins, sampled twice
// Notes:   Data line is open drain: output is always low, enable low drives it
`timescale 1ns/10ps
module rtcb_top import rtcb_pkg::*; #(
    parameter int         OSC_PER_SEC = OSC_HZ,
    parameter logic [6:0] DEV_ID      = SLAVE_ID
) (
    input  wire logic sys_clk_i,
    input  wire logic nrst_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_n_o,
    input  wire logic crystal_input_pin_i,
    output logic      crystal_output_pin_o
);

    localparam int              PRE_W   = $clog2(OSC_PER_SEC);
    localparam logic [PRE_W-1:0] PRE_MAX = PRE_W'(OSC_PER_SEC - 1);

    //--------------------------------------------------------------------
    // Pin synchronisers and edge detection
    //--------------------------------------------------------------------
    logic [1:0] scl_s_r, sda_s_r, xtl_s_r;
    logic       scl_d_r, sda_d_r, xtl_d_r;
    logic       scl_rise, scl_fall, start_det, stop_det, xtl_rise;

    // Two stages; only the second stage feeds the edge registers
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            xtl_s_r <= 2'h0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            xtl_d_r <= 1'b0;
        end else begin
            scl_s_r <= {scl_s_r[0], scl_i};
            sda_s_r <= {sda_s_r[0], sda_i};
            xtl_s_r <= {xtl_s_r[0], crystal_input_pin_i};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
            xtl_d_r <= xtl_s_r[1];
        end
    end

    assign scl_rise  = scl_s_r[1] && !scl_d_r;
    assign scl_fall  = !scl_s_r[1] && scl_d_r;
    assign start_det = scl_s_r[1] && scl_d_r && sda_d_r && !sda_s_r[1];
    assign stop_det  = scl_s_r[1] && scl_d_r && !sda_d_r && sda_s_r[1];
    assign xtl_rise  = xtl_s_r[1] && !xtl_d_r;

    //--------------------------------------------------------------------
    // Seconds prescaler
    //--------------------------------------------------------------------
    logic [PRE_W-1:0] pre_cnt_r;
    logic             sec_tick;
    assign sec_tick = xtl_rise && pre_cnt_r == PRE_MAX;

    // Counts crystal rising edges; crystal output is the inverted drive
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre_cnt_r            <= '0;
            crystal_output_pin_o <= 1'b1;
        end else begin
            crystal_output_pin_o <= ~xtl_s_r[1];
            if (xtl_rise) begin
                pre_cnt_r <= sec_tick ? '0 : pre_cnt_r + 1'b1;
            end
        end
    end

    //--------------------------------------------------------------------
    // Bit engine
    //--------------------------------------------------------------------
    logic [3:0]  cnt_r;
    logic [7:0]  shreg_r;
    logic        mack_r;
    rtcb_state_t st_r;
    logic        byte_done;
    assign byte_done = scl_fall && cnt_r == 4'd8 && st_r != ST_IDLE;

    // Eight data clocks then one acknowledge clock per byte
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r   <= 4'd0;
            shreg_r <= 8'h00;
            mack_r  <= 1'b0;
        end else if (start_det || stop_det) begin
            cnt_r <= 4'd0;
        end else if (scl_rise) begin
            cnt_r <= cnt_r + 4'd1;
            if (cnt_r < 4'd8) begin
                shreg_r <= {shreg_r[6:0], sda_s_r[1]};
            end else begin
                mack_r <= !sda_s_r[1];
            end
        end else if (scl_fall && cnt_r == 4'd9) begin
            cnt_r <= 4'd0;
        end
    end

    //--------------------------------------------------------------------
    // Protocol state, pointer and data line drive
    //--------------------------------------------------------------------
    logic [4:0] ptr_r;
    logic       mem_r, wen_r, drv_r;
    logic [7:0] tx_r, rd_mux;
    logic       id_hit;
    assign id_hit = shreg_r[7:1] == DEV_ID && !shreg_r[CMD_RD_BIT];

    // Acknowledge and data bits change only after a serial clock fall
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r  <= ST_IDLE;
            ptr_r <= 5'h00;
            mem_r <= 1'b0;
            wen_r <= 1'b0;
            drv_r <= 1'b0;
            tx_r  <= 8'h00;
        end else if (start_det) begin
            st_r  <= ST_ID;
            drv_r <= 1'b0;
        end else if (stop_det) begin
            st_r  <= ST_IDLE;
            drv_r <= 1'b0;
        end else if (byte_done) begin
            case (st_r)
                ST_ID: begin
                    drv_r <= id_hit;
                    st_r  <= id_hit ? ST_CMD : ST_IDLE;
                end
                ST_CMD: begin
                    drv_r <= 1'b1;
                    st_r  <= shreg_r[CMD_RD_BIT] ? ST_RD : ST_WR;
                    ptr_r <= (shreg_r[5:1] == IDX_BURST) ? 5'h00 : shreg_r[5:1];
                    mem_r <= shreg_r[CMD_MEM_BIT];
                    wen_r <= shreg_r[CMD_WEN_BIT];
                end
                ST_WR: begin
                    drv_r <= 1'b1;
                    ptr_r <= ptr_r + 5'h01;
                end
                ST_RD: begin
                    drv_r <= 1'b0;
                    ptr_r <= ptr_r + 5'h01;
                end
                default: drv_r <= 1'b0;
            endcase
        end else if (scl_fall && cnt_r == 4'd9 && st_r != ST_IDLE) begin
            if (st_r == ST_RD && mack_r) begin
                tx_r  <= rd_mux;
                drv_r <= !rd_mux[7];
            end else begin
                drv_r <= 1'b0;
                if (st_r == ST_RD) begin
                    st_r <= ST_IDLE;
                end
            end
        end else if (scl_fall && st_r == ST_RD && cnt_r != 4'd0) begin
            tx_r  <= {tx_r[6:0], 1'b0};
            drv_r <= !tx_r[6];
        end
    end

    // Registered open-drain outputs: data is held low, enable releases it
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sda_o      <= 1'b0;
            sda_oe_n_o <= 1'b1;
        end else begin
            sda_o      <= 1'b0;
            sda_oe_n_o <= !drv_r;
        end
    end

    //--------------------------------------------------------------------
    // Writes, latch and scratchpad
    //--------------------------------------------------------------------
    logic       wr_fire, cal_wr, ram_wr;
    logic       latch_pend_r, latch_do;
    logic [7:0] cal_v [0:8];
    logic [7:0] lat_r [0:8];
    logic [7:0] sram_r [0:SRAM_DEPTH-1];

    // Only complete bytes acknowledged with writes enabled take effect
    assign wr_fire  = byte_done && st_r == ST_WR && wen_r;
    assign cal_wr   = wr_fire && !mem_r;
    assign ram_wr   = wr_fire && mem_r && ptr_r < 5'(SRAM_DEPTH);
    // Deferring the copy by a cycle keeps it off the seconds update
    assign latch_do = latch_pend_r && !sec_tick;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            latch_pend_r <= 1'b0;
        end else if (byte_done && st_r == ST_CMD && shreg_r[CMD_RD_BIT]
                     && !shreg_r[CMD_MEM_BIT]) begin
            latch_pend_r <= 1'b1;
        end else if (latch_do) begin
            latch_pend_r <= 1'b0;
        end
    end

    // Holding latch for timekeeping reads; counters keep running
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < 9; i++) begin
                lat_r[i] <= 8'h00;
            end
        end else if (latch_do) begin
            for (int i = 0; i < 9; i++) begin
                lat_r[i] <= cal_v[i];
            end
        end
    end

    // Scratchpad has no reset, like its power-on contents
    always_ff @(posedge sys_clk_i) begin
        if (ram_wr) begin
            sram_r[ptr_r] <= shreg_r;
        end
    end

    // Read source for the next byte out
    always_comb begin
        rd_mux = 8'h00;
        if (mem_r) begin
            if (ptr_r < 5'(SRAM_DEPTH)) begin
                rd_mux = sram_r[ptr_r];
            end
        end else if (ptr_r <= IDX_CTRL) begin
            rd_mux = lat_r[ptr_r[2:0]];
        end else if (ptr_r == IDX_CENT) begin
            rd_mux = lat_r[8];
        end else if (ptr_r == IDX_RSVD) begin
            rd_mux = RST_RSVD;
        end
    end

    rtcb_cal u_cal (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .tick_i    (sec_tick),
        .wr_i      (cal_wr),
        .wr_idx_i  (ptr_r),
        .wr_data_i (shreg_r),
        .sec_o     (cal_v[0]),
        .min_o     (cal_v[1]),
        .hr_o      (cal_v[2]),
        .date_o    (cal_v[3]),
        .mon_o     (cal_v[4]),
        .day_o     (cal_v[5]),
        .year_o    (cal_v[6]),
        .ctrl_o    (cal_v[7]),
        .cent_o    (cal_v[8])
    );

    //--------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------
    idle_release_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (st_r == ST_IDLE && $past(st_r == ST_IDLE)) |=> sda_oe_n_o)
        else $error("data line driven while idle");
    id_miss_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (byte_done && st_r == ST_ID && shreg_r[7:1] != DEV_ID) |=> ##1 sda_oe_n_o)
        else $error("acknowledged a foreign slave identifier");
    gen_call_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (byte_done && st_r == ST_ID && shreg_r == 8'h00)
        |=> st_r == ST_IDLE ##1 sda_oe_n_o)
        else $error("general call was acknowledged");
    wr_block_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (byte_done && st_r == ST_CMD && !shreg_r[CMD_WEN_BIT])
        |=> (!wen_r && !wr_fire && st_r != ST_ID) [*8])
        else $error("write went through with enable bit clear");
    latch_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (latch_pend_r && sec_tick) |=> latch_pend_r ##1 !latch_pend_r)
        else $error("latch copy collided with a seconds update");
    stop_discard_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        stop_det |=> (st_r == ST_IDLE && cnt_r == 4'd0 && !wr_fire))
        else $error("partial byte not discarded on stop");
    tick_count_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        sec_tick |=> pre_cnt_r == '0)
        else $error("prescaler did not restart after a second");

endmodule

// ---- dv/rtcb_mst.sv ----
// Purpose: Serial bus master model for the clock block
// Assumes: Bench resolves the open-drain data wire with a pull-up
// Notes:   Half bit period 40 ns; called from a falling clock edge
`timescale 1ns/10ps
module rtcb_mst (
    output logic      scl_o,
    output logic      sda_o,
    input  wire logic sda_w_i
);
    // Both lines released while idle
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // One bit; data moves only while clock is low
    task automatic bt(input logic b, output logic s);
        sda_o = b;
        #40 scl_o = 1'b1;
        #40 s = sda_w_i;
        scl_o = 1'b0;
    endtask

    // Start, also usable as repeated start
    task automatic sta();
        sda_o = 1'b1;
        #40 scl_o = 1'b1;
        #40 sda_o = 1'b0;
        #40 scl_o = 1'b0;
    endtask

    // Stop, then bus free time
    task automatic stp();
        sda_o = 1'b0;
        #40 scl_o = 1'b1;
        #40 sda_o = 1'b1;
        #40;
    endtask

    // Byte MSB first, then ninth bit; q keeps all nine samples
    task automatic xb(input logic [7:0] d, input logic a9, output logic [8:0] q);
        logic [8:0] v;
        v = {d, a9};
        for (int i = 8; i >= 0; i--) begin
            bt(v[i], q[i]);
        end
    endtask
endmodule

// ---- dv/rtcb_top_tb.sv ----
// Purpose: Self-checking bench for the serial clock block
// Assumes: One second is four crystal edges here
// Notes:   Crystal held still except during tick bursts
`timescale 1ns/10ps
module rtcb_top_tb import rtcb_pkg::*;;
    logic       sys_clk_i = 1'b0;
    logic       nrst_i    = 1'b0;
    logic       xtal      = 1'b0;
    logic       scl, m_sda, sda_o, sda_oe_n, sda_w, xout;
    logic [8:0] q;
    logic [7:0] v, yr, bv [7], ev [7];
    logic [31:0] rows [11];
    int         bad_count, comparisons;
    localparam logic [7:0] ID = {SLAVE_ID, 1'b0};

    // Pull-up wire: either party may pull low
    assign sda_w = m_sda & (sda_oe_n | sda_o);
    always #2.5 sys_clk_i = ~sys_clk_i;
    rtcb_top #(.OSC_PER_SEC(4), .DEV_ID(SLAVE_ID)) DUT (.sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n), .crystal_input_pin_i(xtal), .crystal_output_pin_o(xout));
    rtcb_mst M (.scl_o(scl), .sda_o(m_sda), .sda_w_i(sda_w));

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic summarize();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Start, identifier, command; identifier must be acknowledged
    task automatic hdr(input logic [7:0] c);
        M.sta();
        M.xb(ID, 1'b1, q);
        chk({7'h00, q[0]}, 8'h00);
        M.xb(c, 1'b1, q);
    endtask
    task automatic rd(input logic [7:0] c, output logic [7:0] d);
        hdr(c);
        M.xb(8'hff, 1'b1, q);
        d = q[8:1];
        M.stp();
    endtask

    // Hang guard
    initial begin
        #400000;
        bad_count++;
        summarize();
    end
    //----------------------------------------------------------------
    // Main sequence
    //----------------------------------------------------------------
    initial begin
        // Rows: write cmd, data (cmd 00 skips), read cmd, expected
        rows = '{32'h0000_8100, 32'h0000_8701, 32'h0000_8d70, 32'h0000_9319,
                 32'h0000_9707, 32'h8e55_8f55, 32'hc0a5_c1a5, 32'hfc3c_fd3c,
                 32'h405a_c1a5, 32'h8631_8731, 32'h8812_8912};
        repeat (12) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        foreach (rows[i]) begin
            if (rows[i][31:24] != 8'h00) begin
                hdr(rows[i][31:24]);
                M.xb(rows[i][23:16], 1'b1, q);
                M.stp();
            end
            rd(rows[i][15:8], v);
            chk(v, rows[i][7:0]);
        end
        // General call and foreign identifier: no ack, no write
        for (int j = 0; j < 2; j++) begin
            M.sta();
            M.xb(j ? {SLAVE_ID ^ 7'h01, 1'b0} : 8'h00, 1'b1, q);
            chk({7'h00, q[0]}, 8'h01);
            M.xb(8'hc0, 1'b1, q);
            M.xb(8'h77, 1'b1, q);
            M.stp();
        end
        // Byte cut short by stop after four bits
        hdr(8'hc0);
        repeat (4) M.bt(1'b0, q[0]);
        M.stp();
        rd(8'hc1, v);
        chk(v, 8'ha5);
        // Feb 28 in leap year 04, plain year 03, then 12-hour PM 11 on Dec 31 99
        for (int j = 0; j < 3; j++) begin
            yr = j[0] ? 8'h03 : 8'h04;
            bv = '{8'h59, 8'h59, 8'h23, 8'h28, 8'h02, 8'h05, yr};
            ev = '{8'h00, 8'h00, 8'h00, j[0] ? 8'h01 : 8'h29, j[0] ? 8'h03 : 8'h02, 8'h06, yr};
            if (j == 2) begin
                bv = '{8'h59, 8'h59, 8'hb1, 8'h31, 8'h12, 8'h07, 8'h99};
                ev = '{8'h00, 8'h00, 8'h92, 8'h01, 8'h01, 8'h01, 8'h00};
            end
            hdr(8'hbe);
            foreach (bv[k]) M.xb(bv[k], 1'b1, q);
            M.stp();
            // One second of crystal edges, then still again
            repeat (4) begin
                #100 xtal = 1'b1;
                #100 chk({7'h00, xout}, 8'h00);
                xtal = 1'b0;
            end
            hdr(8'hbf);
            foreach (ev[k]) begin
                M.xb(8'hff, k == 6, q);
                chk(q[8:1], ev[k]);
            end
            M.stp();
        end
        rd(8'h93, v);
        chk(v, 8'h20);
        // Tick lands one cycle after the read command: the copy must wait
        repeat (3) begin
            #100 xtal = 1'b1;
            #100 xtal = 1'b0;
        end
        #100 chk({7'h00, xout}, 8'h01);
        fork
            hdr(8'h81);
            begin
                #1485 xtal = 1'b1;
                #100 xtal = 1'b0;
            end
        join
        M.xb(8'hff, 1'b1, q);
        M.stp();
        chk(q[8:1], 8'h01);
        // Reset in mid-run: line released, year register back to its reset value
        nrst_i = 1'b0;
        @(negedge sys_clk_i);
        chk({6'h00, sda_oe_n, sda_o}, 8'h02);
        repeat (2) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        rd(8'h8d, v);
        chk(v, RST_YEAR);
        summarize();
    end
endmodule
